// ### logic/asa_smi_status.sv
// Second-level audio SMI status: sticky cause bits, read-clear primary
// register, non-clearing mirror, trap detail register and top-level request.
// Reset leaves every flag, enable and the read word at zero.
// Codec control words keep only their enable bits.
// Assumes bus-master engines, codec link and trap decoder drive the inputs
// synchronously to clk and keep their end-of-page flags as levels.
`timescale 1ns/100ps
`default_nettype none
module asa_smi_status #(
  parameter int NUM_MASTERS = asa_pkg::NUM_BM
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Register port
  input  wire asa_pkg::asa_mem_req_t      memReq,
  output var  logic [asa_pkg::DATA_W-1:0] memRdata,
  // Bus-master engines
  input  wire logic [NUM_MASTERS-1:0]     bmEnable,
  input  wire logic [NUM_MASTERS-1:0]     bmEndOfPage,
  // Codec link
  input  wire logic                       codecSerialIrq,
  input  wire logic                       codecGpioIrq,
  // Trap decoder
  input  wire logic                       ioTrapHit,
  input  wire logic [asa_pkg::TRAP_W-1:0] ioTrapCause,
  // Top-level SMI status logic
  output var  logic                       smiRequest,
  output var  logic [asa_pkg::CAUSE_W-1:0] smiCause
);
  import asa_pkg::*;

  logic                   serSmiEn;
  logic                   gpioSmiEn;
  logic                   rdPrimary;
  logic                   rdTrap;
  logic                   wrSerCtl;
  logic                   wrGpioCtl;
  logic                   serEvent;
  logic                   gpioEvent;
  logic                   codecEvent;
  logic [NUM_MASTERS-1:0] bmSet;
  logic [STAT_W-1:0]      status;
  logic [STAT_W-1:0]      statusWord;
  logic [STAT_W-1:0]      statusSet;
  logic [STAT_W-1:0]      statusClear;
  logic [STAT_W-1:0]      bmBusy;
  logic [TRAP_W-1:0]      trapStatus;
  logic [TRAP_W-1:0]      trapSet;
  logic [TRAP_W-1:0]      trapClear;
  logic [DATA_W-1:0]      gpioCtlWord;
  logic [DATA_W-1:0]      serCtlWord;
  logic [DATA_W-1:0]      next_memRdata;

  // Mask of the implemented cause bits; bits 15:8 stay reserved
  function automatic logic [STAT_W-1:0] causeMask();
    causeMask = {{(STAT_W-CAUSE_W){1'b0}}, {CAUSE_W{1'b1}}};
  endfunction : causeMask

  // Read strobe decode for one offset
  function automatic logic rdHit(asa_mem_req_t r, logic [ADDR_W-1:0] off);
    rdHit = r.read && (r.addr == off);
  endfunction : rdHit

  // Write strobe decode for one offset
  function automatic logic wrHit(asa_mem_req_t r, logic [ADDR_W-1:0] off);
    wrHit = r.write && (r.addr == off);
  endfunction : wrHit

  // Strobes of the mapped offsets
  assign rdPrimary = rdHit(memReq, OFF_STAT_PRIMARY);
  assign rdTrap    = rdHit(memReq, OFF_TRAP_STAT);
  assign wrSerCtl  = wrHit(memReq, OFF_CODEC_SER_CTL);
  assign wrGpioCtl = wrHit(memReq, OFF_CODEC_GPIO_CTL);

  // Codec serial interrupt enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serSmiEn <= 1'b0;
    end else if (wrSerCtl) begin
      serSmiEn <= memReq.wdata[BIT_SER_SMI_EN];
    end
  end

  // Codec pin interrupt enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpioSmiEn <= 1'b0;
    end else if (wrGpioCtl) begin
      gpioSmiEn <= memReq.wdata[BIT_GPIO_SMI_EN];
    end
  end

  // Control words as read back, other bits reading zero
  always_comb begin
    gpioCtlWord                  = RD_ZERO;
    serCtlWord                   = RD_ZERO;
    gpioCtlWord[BIT_GPIO_SMI_EN] = gpioSmiEn;
    serCtlWord[BIT_SER_SMI_EN]   = serSmiEn;
  end

  // Codec causes qualified by their enables
  assign serEvent   = codecSerialIrq && serSmiEn;
  assign gpioEvent  = codecGpioIrq && gpioSmiEn;
  assign codecEvent = serEvent || gpioEvent;

  // Level-sensitive: re-sets every cycle while an enabled master's page end is pending
  assign bmSet = bmEnable & bmEndOfPage;

  // Set terms of the status vector
  always_comb begin
    statusSet = '0;
    statusSet[BIT_IO_TRAP] = ioTrapHit;
    statusSet[BIT_CODEC]   = codecEvent;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      // Bits 2..7 follow masters 0..5
      statusSet[BIT_BM_FIRST+i] = bmSet[i];
    end
  end

  // Clear terms: a primary read, minus masters still at end of page
  always_comb begin
    bmBusy      = '0;
    statusClear = '0;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      bmBusy[BIT_BM_FIRST+i] = bmEndOfPage[i];
    end
    if (rdPrimary) begin
      statusClear = causeMask() & ~bmBusy;
    end
  end

  // Cause flags; set wins, so an event in the read cycle is kept
  asa_sticky_flags #(
    .WIDTH     (STAT_W)
  ) u_status (
    .clk       (clk),
    .nrst      (nrst),
    .setBits   (statusSet & causeMask()),
    .clearBits (statusClear),
    .flags     (status)
  );

  // Word shown at both status offsets
  assign statusWord = status & causeMask();

  // Trap detail gathered only in cycles that carry a trap
  assign trapSet = ioTrapHit ? ioTrapCause : RST_TRAP;

  // Trap detail, cleared when read
  assign trapClear = rdTrap ? ~RST_TRAP : RST_TRAP;

  // Trap detail flags
  asa_sticky_flags #(
    .WIDTH     (TRAP_W)
  ) u_trap (
    .clk       (clk),
    .nrst      (nrst),
    .setBits   (trapSet),
    .clearBits (trapClear),
    .flags     (trapStatus)
  );

  // Read data mux
  always_comb begin
    next_memRdata = RD_ZERO;
    if (memReq.read) begin
      case (memReq.addr)
        OFF_CODEC_GPIO_CTL: begin
          next_memRdata = gpioCtlWord;
        end
        OFF_CODEC_SER_CTL: begin
          next_memRdata = serCtlWord;
        end
        OFF_STAT_PRIMARY: begin
          next_memRdata[STAT_W-1:0] = statusWord;
        end
        OFF_STAT_MIRROR: begin
          next_memRdata[STAT_W-1:0] = statusWord;
        end
        OFF_TRAP_STAT: begin
          next_memRdata[TRAP_W-1:0] = trapStatus;
        end
        default: begin
          next_memRdata = RD_ZERO;
        end
      endcase
    end
  end

  // Held between reads so a slow reader still sees its word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memRdata <= RD_ZERO;
    end else if (memReq.read) begin
      memRdata <= next_memRdata;
    end
  end

  // Request is an OR of flops, so it does not glitch toward the top
  assign smiCause   = status[CAUSE_W-1:0];
  assign smiRequest = |status;

endmodule : asa_smi_status
`default_nettype wire

// ### logic/asa_pkg.sv
// Package for the audio SMI status aggregator: offsets, bit layout,
// reset values and the register-port request carrier.
// Assumes byte offsets relative to the audio memory base.
package asa_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STAT_W = 16;
  localparam int NUM_BM = 6;
  localparam int TRAP_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CODEC_GPIO_CTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CODEC_SER_CTL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STAT_PRIMARY   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STAT_MIRROR    = 8'h12;
  localparam logic [ADDR_W-1:0] OFF_TRAP_STAT      = 8'h14;

  // Enable bit positions in the codec control words
  localparam int BIT_GPIO_SMI_EN = 30;
  localparam int BIT_SER_SMI_EN  = 23;

  // Status bit positions
  localparam int BIT_IO_TRAP  = 0;
  localparam int BIT_CODEC    = 1;
  localparam int BIT_BM_FIRST = 2;
  localparam int CAUSE_W      = 8;

  // Reset values
  localparam logic [STAT_W-1:0] RST_STATUS = 16'h0000;
  localparam logic [TRAP_W-1:0] RST_TRAP   = 16'h0000;
  localparam logic [DATA_W-1:0] RD_ZERO    = 32'h0000_0000;

  // Register-port request
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asa_mem_req_t;

endpackage : asa_pkg

// ### logic/asa_sticky_flags.sv
// Sticky flag vector: per-bit set and clear, set wins over clear.
// Assumes set and clear are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module asa_sticky_flags #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Flag control
  input  wire logic [WIDTH-1:0] setBits,
  input  wire logic [WIDTH-1:0] clearBits,
  // Flag state
  output var  logic [WIDTH-1:0] flags
);

  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clearBits) | setBits;
    end
  end

endmodule : asa_sticky_flags
`default_nettype wire

// ### test/asa_smi_status_properties.sv
// Port checker for the audio SMI status aggregator.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module asa_smi_status_checker #(
  parameter int NUM_MASTERS = asa_pkg::NUM_BM
) (
  // Watched ports
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire asa_pkg::asa_mem_req_t      memReq,
  input wire logic [asa_pkg::DATA_W-1:0] memRdata,
  input wire logic [NUM_MASTERS-1:0]     bmEnable,
  input wire logic [NUM_MASTERS-1:0]     bmEndOfPage,
  input wire logic                       codecSerialIrq,
  input wire logic                       codecGpioIrq,
  input wire logic                       ioTrapHit,
  input wire logic [asa_pkg::TRAP_W-1:0] ioTrapCause,
  input wire logic                       smiRequest,
  input wire logic [asa_pkg::CAUSE_W-1:0] smiCause
);
  import asa_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic [7:0] hit = {bmEnable & bmEndOfPage, 2'b00};
  sequence rdStat;
    memReq.read && memReq.addr == OFF_STAT_PRIMARY;
  endsequence
  sequence quiet;
    !(|bmEndOfPage) && !codecSerialIrq && !codecGpioIrq && !ioTrapHit;
  endsequence
  AST_BM0: assert property (hit[2] |=> smiCause[2]) else $error("bm0");
  AST_BM1: assert property (hit[3] |=> smiCause[3]) else $error("bm1");
  AST_BM3: assert property (hit[5] |=> smiCause[5]) else $error("bm3");
  AST_BM4: assert property (hit[6] |=> smiCause[6]) else $error("bm4");
  AST_BM5: assert property (hit[7] |=> smiCause[7]) else $error("bm5");
  AST_TRAP: assert property (ioTrapHit |=> smiCause[0]) else $error("trap");
  AST_REQ: assert property (smiRequest == (smiCause != 8'h00))
    else $error("request");
  AST_HOLD: assert property (
    ($past(smiCause[7:2]) & $past(bmEndOfPage) & ~smiCause[7:2]) == 6'h00)
    else $error("hold");
  AST_CLR: assert property (rdStat ##0 quiet |=> smiCause == 8'h00)
    else $error("clear");
  AST_MIR: assert property (
    memReq.read && memReq.addr == OFF_STAT_MIRROR |=>
    memRdata[7:0] == $past(smiCause) && ($past(smiCause) & ~smiCause) == 0)
    else $error("mirror");
  AST_RSVD: assert property (memReq.read && (
    memReq.addr == OFF_STAT_PRIMARY || memReq.addr == OFF_STAT_MIRROR)
    |=> memRdata[31:8] == 24'h0) else $error("reserved");
endmodule : asa_smi_status_checker
bind asa_smi_status asa_smi_status_checker #(.NUM_MASTERS(NUM_MASTERS)) chk (
  .clk(clk), .nrst(nrst), .memReq(memReq), .memRdata(memRdata),
  .bmEnable(bmEnable), .bmEndOfPage(bmEndOfPage), .ioTrapHit(ioTrapHit),
  .codecSerialIrq(codecSerialIrq), .codecGpioIrq(codecGpioIrq),
  .ioTrapCause(ioTrapCause), .smiRequest(smiRequest), .smiCause(smiCause));
`default_nettype wire

// ### test/asa_top_smi_model.sv
// Top-level SMI status model: gathers causes while the request is high.
// Assumes the aggregator's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module asa_top_smi_model (
  // Clock, reset and second-level request
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       smiRequest,
  input  wire logic [7:0] smiCause,
  // Gathered causes
  output var  logic [7:0] topSeen
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) topSeen <= 8'h00;
    else if (smiRequest) topSeen <= topSeen | smiCause;
  end
endmodule : asa_top_smi_model
`default_nettype wire

// ### test/audio_smi_status_aggregator_tb_top.sv
// Self-checking bench for the audio SMI status aggregator.
// Assumes the checker and the top-level model are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module audio_smi_status_aggregator_tb_top;
  import asa_pkg::*;
  logic clk, nrst, sIrq, gIrq, trap, smiReq;
  asa_mem_req_t req;
  logic [31:0] rdata;
  logic [5:0]  en, eop;
  logic [15:0] tc;
  logic [7:0]  cause, topSeen, e;
  int          fail_count, compares, i, k;
  asa_smi_status dut (.clk(clk), .nrst(nrst), .memReq(req),
    .memRdata(rdata), .bmEnable(en), .bmEndOfPage(eop),
    .codecSerialIrq(sIrq), .codecGpioIrq(gIrq), .ioTrapHit(trap),
    .ioTrapCause(tc), .smiRequest(smiReq), .smiCause(cause));
  asa_top_smi_model top (.clk(clk), .nrst(nrst), .smiRequest(smiReq),
    .smiCause(cause), .topSeen(topSeen));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] bmExp(input logic [5:0] n, p);
    return {n & p, 2'b00};
  endfunction : bmExp
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic r, input logic [7:0] a, input logic [31:0] d);
    req = '{read: r, write: !r, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b1, a, 32'h0);
    chk(rdata, exp);
  endtask : rd
  task automatic give_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    {nrst, sIrq, gIrq, trap, en, eop, tc, fail_count, compares} = '0;
    req = '0;
    k = $urandom(26);
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rd(OFF_STAT_MIRROR, 32'h0);
    for (i = 0; i < 24; i++) begin
      eop = (i < 6) ? 6'h01 << i : 6'($urandom);
      en = (i < 6) ? eop : 6'($urandom);
      e = bmExp(en, eop);
      @(negedge clk);
      {en, eop} = '0;
      chk({31'h0, smiReq}, {31'h0, e != 8'h00});
      chk({24'h0, cause}, {24'h0, e});
      rd(OFF_STAT_MIRROR, {24'h0, e});
      rd(OFF_STAT_PRIMARY, {24'h0, e});
      rd(OFF_STAT_PRIMARY, 32'h0);
    end
    {en, eop} = 12'h041;
    @(negedge clk);
    rd(OFF_STAT_PRIMARY, 32'h4);
    rd(OFF_STAT_MIRROR, 32'h4);
    eop = '0;
    rd(OFF_STAT_PRIMARY, 32'h4);
    rd(OFF_STAT_PRIMARY, 32'h0);
    for (k = 0; k < 4; k++) begin
      acc(1'b0, k[1] ? OFF_CODEC_GPIO_CTL : OFF_CODEC_SER_CTL,
        k[0] ? 32'h1 << (k[1] ? BIT_GPIO_SMI_EN : BIT_SER_SMI_EN) : 32'h0);
      {gIrq, sIrq} = k[1] ? 2'b10 : 2'b01;
      @(negedge clk);
      {gIrq, sIrq} = '0;
      rd(OFF_STAT_PRIMARY, k[0] ? 32'h2 : 32'h0);
    end
    tc = 16'($urandom);
    trap = 1'b1;
    @(negedge clk);
    trap = 1'b0;
    rd(OFF_TRAP_STAT, {16'h0, tc});
    rd(OFF_STAT_PRIMARY, 32'h1);
    acc(1'b0, OFF_STAT_MIRROR, 32'h00ff);
    rd(OFF_STAT_MIRROR, 32'h0);
    rd(8'hf0, 32'h0);
    chk({24'h0, topSeen}, 32'hff);
    give_verdict();
  end
endmodule : audio_smi_status_aggregator_tb_top
`default_nettype wire
